// ==== uc_pkg.sv ====
// uc_pkg: register map, frame constants and carrier types of the serial control block
// assumes one 100 MHz module clock and a byte-wide register port with 2 address bits
package uc_pkg;
   // register word addresses
   localparam logic [1:0] ADDR_LINE = 2'h0;
   localparam logic [1:0] ADDR_XFER = 2'h1;
   localparam logic [1:0] ADDR_STAT = 2'h2;
   localparam logic [1:0] ADDR_DATA = 2'h3;
   // both control registers clear to all zeros
   localparam logic [7:0] CTL_RESET = 8'h00;
   // whole character length in bit times, start and stop included
   localparam logic [3:0] FRAME_LEN8 = 4'ha;
   localparam logic [3:0] FRAME_LEN9 = 4'hb;
   // bit timing: module clock rate and default line rate
   localparam int CLK_HZ = 100000000;
   localparam int BAUD_DEF = 115200;
   localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_DEF;
   // line format control, most significant bit first
   typedef struct packed {
      logic loop_back_select;
      logic uart_on;
      logic tx_polarity_flip;
      logic nine_bit_select;
      logic rouse_condition_sel;
      logic idle_count_origin;
      logic parity_on;
      logic odd_parity_sel;
   } uc_line_t;
   // transfer control, most significant bit first
   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic rx_full_irq_en;
      logic idle_irq_en;
      logic tx_on;
      logic rx_on;
      logic rx_standby;
      logic break_send;
   } uc_xfer_t;
   // status as software reads it
   typedef struct packed {
      logic tx_buffer_empty;
      logic tx_done;
      logic rx_full;
      logic idle;
      logic [3:0] unused;
   } uc_stat_t;
   typedef enum {TX_IDLE, TX_SHIFT} uc_tx_st_t;
   typedef enum {RX_HUNT, RX_SHIFT} uc_rx_st_t;
endpackage

// ==== uc_top.sv ====
// uc_top: serial transceiver control, line format, power modes and pin override
// assumes register strobes come from logic on mclk_i; rx pin is asynchronous
// Notes on behaviour
// - keeps running in wait mode; enabled requests reach the interrupt outputs
// - stop mode freezes engines and flags, registers kept, resumes afterward
// - in debug break with clear allowed, status clears work and persist
// - in debug break without clear allowed, flags hold; armed first steps persist
// - module enabled: transmit pin is an output carrying serial data
// - module enabled: receive pin is an input for the receiver
// - loopback routes transmitter output into receiver, pin disconnected
// - uart_on enables bit timing; clearing it sets empty and done flags
// - polarity flip inverts every transmitted level, idle included
// - nine_bit_select picks 10 or 11 bit characters
// - parity replaces the top data position, frame length unchanged
// - odd_parity_sel picks odd or even parity; software avoids mid-character change
// - rouse_condition_sel picks address-mark or idle-line wakeup
// - idle_count_origin starts counting ones after stop or after start
// - all control bits clear to zero on reset
// - transmit request from empty or done flag with its enable
// - receive request from full or idle flag with its enable
// - rising tx_on sends a preamble of 10 or 11 ones
// - clearing tx_on finishes the current character, then line idles high
// - clearing and setting tx_on mid-character queues one idle character
// - rx_on enables receiver; clearing it leaves receive flags alone
// - rx_standby mutes receive requests until wakeup or reset clears it
// - break_send sends break characters, then a single one when dropped
`timescale 1ns/100ps
module uc_top #(
   parameter int DIV = uc_pkg::BIT_CYCLES_DEF
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic dbg_break_i,
   input wire logic break_clear_allow_i,
   input wire logic pin0_direction_i,
   input wire logic pin1_direction_i,
   input wire logic port_tx_data_i,
   input wire logic port_rx_data_i,
   output logic tx_pin_o,
   output logic tx_pin_oe_o,
   input wire logic rx_pin_i,
   output logic rx_pin_o,
   output logic rx_pin_oe_o,
   output logic tx_irq_o,
   output logic rx_irq_o
);
   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] BIT_END = CW'(DIV - 1);
   localparam logic [CW-1:0] HALF_BIT = CW'(DIV / 2);

   uc_pkg::uc_line_t line_ctl;
   uc_pkg::uc_xfer_t xfer_ctl;
   uc_pkg::uc_xfer_t wx;
   uc_pkg::uc_stat_t stat_v;
   uc_pkg::uc_tx_st_t tst;
   uc_pkg::uc_rx_st_t rst;
   logic run, clr_ok, rx_en;
   logic wr_xfer, rd_stat, rd_data, wr_data;
   logic tbe, tdn, arm_tbe, pre_pend, need_mark;
   logic rxf, idl, arm_rxf, arm_idl, idle_arm;
   logic [7:0] tx_hold, rx_data;
   logic [10:0] tsh, rsh, tframe, rfr;
   logic [3:0] tleft, rleft, flen, icnt;
   logic [CW-1:0] tcnt, rcnt;
   logic tend, slot, tx_ok, go_pre, go_brk, go_mark, go_data, go_any;
   logic tx_raw, par, rs1, rs2, rin, rend, rdone, rmsb;
   logic idle_hit, idle_set, rx_take, wake_mark, wake_idle;

   // decode of the register port; stop mode halts engines, not the port
   assign run = !stop_mode_i;
   assign clr_ok = !dbg_break_i || break_clear_allow_i;
   assign wx = wdata_i;
   assign wr_xfer = wr_i && addr_i == uc_pkg::ADDR_XFER;
   assign rd_stat = rd_i && addr_i == uc_pkg::ADDR_STAT;
   assign rd_data = rd_i && addr_i == uc_pkg::ADDR_DATA;
   assign wr_data = wr_i && addr_i == uc_pkg::ADDR_DATA;
   assign flen = line_ctl.nine_bit_select ? uc_pkg::FRAME_LEN9 : uc_pkg::FRAME_LEN8;
   assign rx_en = line_ctl.uart_on && xfer_ctl.rx_on;

   // control registers; standby drops on either wakeup condition
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         line_ctl <= uc_pkg::CTL_RESET;
         xfer_ctl <= uc_pkg::CTL_RESET;
      end else begin
         if (wr_i && addr_i == uc_pkg::ADDR_LINE)
            line_ctl <= wdata_i;
         if (wr_xfer)
            xfer_ctl <= wdata_i;
         else if (wake_mark || wake_idle)
            xfer_ctl.rx_standby <= 1'b0;
      end
   end

   // a rising tx_on asks for a preamble; covers the off-on idle queue too
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !line_ctl.uart_on)
         pre_pend <= 1'b0;
      else if (wr_xfer && wx.tx_on && !xfer_ctl.tx_on)
         pre_pend <= 1'b1;
      else if (go_pre)
         pre_pend <= 1'b0;
   end

   // transmit character: parity takes the top data position
   always_comb begin
      par = line_ctl.nine_bit_select ? ^tx_hold : ^tx_hold[6:0];
      par = par ^ line_ctl.odd_parity_sel;
      if (line_ctl.nine_bit_select)
         tframe = {1'b1, line_ctl.parity_on ? par : 1'b0, tx_hold, 1'b0};
      else
         tframe = {2'b11, line_ctl.parity_on ? par : tx_hold[7], tx_hold[6:0], 1'b0};
   end

   // load decisions at idle or at the last bit edge, so breaks run seamless
   always_comb begin
      tend = tcnt == BIT_END;
      slot = tst == uc_pkg::TX_IDLE || (tend && tleft == 4'h1);
      tx_ok = slot && xfer_ctl.tx_on && run && line_ctl.uart_on;
      go_pre = tx_ok && pre_pend;
      go_brk = tx_ok && !pre_pend && xfer_ctl.break_send;
      go_mark = tx_ok && !pre_pend && !xfer_ctl.break_send && need_mark;
      go_data = tx_ok && !pre_pend && !xfer_ctl.break_send && !need_mark && !tbe;
      go_any = go_pre || go_brk || go_mark || go_data;
   end

   // transmit shifter; uart_on low stops the bit timer altogether
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !line_ctl.uart_on) begin
         tst <= uc_pkg::TX_IDLE;
         tsh <= '1;
         tleft <= 4'h0;
         tcnt <= '0;
         need_mark <= 1'b0;
      end else if (run) begin
         if (go_any) begin
            tst <= uc_pkg::TX_SHIFT;
            tcnt <= '0;
            tleft <= go_mark ? 4'h1 : flen;
            need_mark <= go_brk;
            if (go_pre || go_mark)
               tsh <= '1;
            else if (go_brk)
               tsh <= '0;
            else
               tsh <= tframe;
         end else if (tst == uc_pkg::TX_SHIFT) begin
            if (tend) begin
               tcnt <= '0;
               tsh <= {1'b1, tsh[10:1]};
               tleft <= tleft - 4'h1;
               if (tleft == 4'h1)
                  tst <= uc_pkg::TX_IDLE;
            end else begin
               tcnt <= tcnt + 1'b1;
            end
         end
      end
   end
   assign tx_raw = tst == uc_pkg::TX_SHIFT ? tsh[0] : 1'b1;

   // transmit flags: two-step clear of empty, hardware set wins over the clear; done clears on any load
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !line_ctl.uart_on) begin
         tbe <= 1'b1;
         tdn <= 1'b1;
         arm_tbe <= 1'b0;
      end else if (run) begin
         if (rd_stat && tbe && clr_ok)
            arm_tbe <= 1'b1;
         if (wr_data && arm_tbe && clr_ok) begin
            tbe <= 1'b0;
            arm_tbe <= 1'b0;
         end
         if (go_data)
            tbe <= 1'b1;
         if (go_any)
            tdn <= 1'b0;
         else if (tbe && tst == uc_pkg::TX_IDLE)
            tdn <= 1'b1;
      end
   end

   // transmit holding register, written whenever software writes data
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i)
         tx_hold <= 8'h00;
      else if (wr_data)
         tx_hold <= wdata_i;
   end

   // receive pin synchroniser; only the second stage is read
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rs1 <= 1'b1;
         rs2 <= 1'b1;
      end else begin
         rs1 <= rx_pin_i;
         rs2 <= rs1;
      end
   end
   assign rin = line_ctl.loop_back_select ? tx_raw : rs2;

   // receive framing: sample mid-bit, ones counted toward idle
   always_comb begin
      rend = rcnt == BIT_END;
      rfr = {rin, rsh[10:1]};
      rdone = rx_en && run && rst == uc_pkg::RX_SHIFT && rend && rleft == 4'h1;
      rmsb = rfr[9]; // top data position in both lengths
      idle_hit = rx_en && run && rend && rin && icnt == flen - 4'h1;
      wake_mark = rdone && xfer_ctl.rx_standby && line_ctl.rouse_condition_sel && rmsb;
      wake_idle = idle_hit && xfer_ctl.rx_standby && !line_ctl.rouse_condition_sel;
      rx_take = rdone && (!xfer_ctl.rx_standby || wake_mark);
      idle_set = idle_hit && idle_arm && !xfer_ctl.rx_standby;
   end

   // receive shifter and idle counter
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !rx_en) begin
         rst <= uc_pkg::RX_HUNT;
         rsh <= '1;
         rleft <= 4'h0;
         rcnt <= '0;
         icnt <= 4'h0;
      end else if (run) begin
         rcnt <= rend ? '0 : rcnt + 1'b1;
         if (rend && icnt != flen)
            icnt <= rin ? icnt + 4'h1 : 4'h0;
         unique case (rst)
            uc_pkg::RX_HUNT: begin
               if (!rin) begin
                  rst <= uc_pkg::RX_SHIFT;
                  rcnt <= HALF_BIT;
                  rleft <= flen;
                  icnt <= 4'h0;
               end
            end
            uc_pkg::RX_SHIFT: begin
               if (line_ctl.idle_count_origin)
                  icnt <= 4'h0;
               if (rend) begin
                  rsh <= rfr;
                  rleft <= rleft - 4'h1;
                  if (rleft == 4'h1)
                     rst <= uc_pkg::RX_HUNT;
               end
            end
         endcase
      end
   end

   // receive flags; rx_on off leaves them as they are
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rxf <= 1'b0;
         idl <= 1'b0;
         arm_rxf <= 1'b0;
         arm_idl <= 1'b0;
         idle_arm <= 1'b0;
      end else if (run) begin
         if (rd_stat && clr_ok) begin
            arm_rxf <= rxf || arm_rxf;
            arm_idl <= idl || arm_idl;
         end
         if (rd_data && clr_ok) begin
            if (arm_rxf)
               rxf <= 1'b0;
            if (arm_idl)
               idl <= 1'b0;
            arm_rxf <= 1'b0;
            arm_idl <= 1'b0;
         end
         if (rx_take) begin
            rxf <= 1'b1;
            idle_arm <= 1'b1;
         end
         if (idle_set) begin
            idl <= 1'b1;
            idle_arm <= 1'b0;
         end
      end
   end

   // received byte; an unread one is kept, the newer character dropped
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i)
         rx_data <= 8'h00;
      else if (rx_take && !rxf)
         rx_data <= line_ctl.nine_bit_select ? rfr[8:1] : rfr[9:2];
   end

   // read data stand one cycle after the strobe and are zero otherwise
   assign stat_v = '{tx_buffer_empty: tbe, tx_done: tdn, rx_full: rxf, idle: idl,
                     unused: 4'h0};
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !rd_i)
         rdata_o <= 8'h00;
      else begin
         unique case (addr_i)
            uc_pkg::ADDR_LINE: rdata_o <= line_ctl;
            uc_pkg::ADDR_XFER: rdata_o <= xfer_ctl;
            uc_pkg::ADDR_STAT: rdata_o <= stat_v;
            uc_pkg::ADDR_DATA: rdata_o <= rx_data;
         endcase
      end
   end

   // interrupt requests stay live in wait mode, so they can wake the core
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tx_irq_o <= 1'b0;
         rx_irq_o <= 1'b0;
      end else begin
         tx_irq_o <= line_ctl.uart_on && ((tbe && xfer_ctl.tx_empty_irq_en) ||
                     (tdn && xfer_ctl.tx_done_irq_en));
         rx_irq_o <= !xfer_ctl.rx_standby && ((rxf && xfer_ctl.rx_full_irq_en) ||
                     (idl && xfer_ctl.idle_irq_en));
      end
   end

   // pin override; port direction only matters while the module is off
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tx_pin_o <= 1'b0;
         tx_pin_oe_o <= 1'b0;
         rx_pin_o <= 1'b0;
         rx_pin_oe_o <= 1'b0;
      end else begin
         tx_pin_o <= line_ctl.uart_on ? tx_raw ^ line_ctl.tx_polarity_flip : port_tx_data_i;
         tx_pin_oe_o <= line_ctl.uart_on || pin0_direction_i;
         rx_pin_o <= port_rx_data_i;
         rx_pin_oe_o <= !line_ctl.uart_on && pin1_direction_i;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   a_tx_pin_out: assert property (line_ctl.uart_on |=> tx_pin_oe_o)
      else $error("tx pin not driven while enabled");
   a_rx_pin_in: assert property (line_ctl.uart_on |=> !rx_pin_oe_o)
      else $error("rx pin driven while enabled");
   a_off_sets_flags: assert property (!line_ctl.uart_on |=> tbe && tdn)
      else $error("disable did not set empty and done");
   a_tx_idle_inv: assert property (line_ctl.uart_on && line_ctl.tx_polarity_flip &&
      tst == uc_pkg::TX_IDLE |=> !tx_pin_o)
      else $error("idle level not inverted");
   a_tx_req: assert property (line_ctl.uart_on && tbe && xfer_ctl.tx_empty_irq_en
      |=> tx_irq_o)
      else $error("transmit request missing");
   a_rx_req: assert property (rxf && xfer_ctl.rx_full_irq_en && !xfer_ctl.rx_standby
      |=> rx_irq_o)
      else $error("receive request missing");
   a_standby_mute: assert property (xfer_ctl.rx_standby |=> !rx_irq_o)
      else $error("receive request in standby");
   a_break_guard: assert property (dbg_break_i && !break_clear_allow_i && rxf
      |=> rxf)
      else $error("flag cleared in protected break");
   a_stop_hold: assert property (stop_mode_i && !wr_i |=> $stable(tsh) && $stable(rsh)
      && $stable(rxf) && $stable(tbe))
      else $error("state moved in stop mode");
   a_preamble_len: assert property (go_pre && !line_ctl.nine_bit_select && !wr_i
      |=> tleft == uc_pkg::FRAME_LEN8 && &tsh)
      else $error("preamble length wrong");
   a_rx_off_flags: assert property (!xfer_ctl.rx_on && !rd_i |=> $stable(rxf) &&
      $stable(idl))
      else $error("receive flags moved while off");
endmodule

// ==== uc_remote.sv ====
// uc_remote: behavioural far-end transceiver for the serial control block
// assumes a bit time of DIV module clocks and a line that rests high
`timescale 1ns/100ps
module uc_remote #(
   parameter int DIV = 8
) (
   input wire logic clk_i,
   input wire logic en_i,
   input wire logic inv_i,
   input wire logic nine_i,
   input wire logic line_i,
   output logic line_o
);
   logic [8:0] got;
   logic got_stop;
   int got_cnt = 0;
   time start_t;
   initial line_o = 1'b1;
   // frame decoder; samples mid bit, so small edge jitter is harmless
   always begin
      @(posedge clk_i);
      if (en_i && ((line_i ^ inv_i) === 1'b0)) begin
         start_t = $time;
         repeat (DIV / 2) @(posedge clk_i);
         got = '0;
         for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
            repeat (DIV) @(posedge clk_i);
            got[i] = line_i ^ inv_i;
         end
         repeat (DIV) @(posedge clk_i);
         got_stop = line_i ^ inv_i;
         got_cnt++;
      end
   end
   // start, n bits lsb first, stop; line rests high afterwards
   task automatic send(input logic [8:0] bits, input int n);
      for (int i = -1; i <= n; i++) begin
         @(posedge clk_i);
         line_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : bits[i];
         repeat (DIV - 1) @(posedge clk_i);
      end
   endtask
endmodule

// ==== uart_control_and_power_modes_test.sv ====
// uart_control_and_power_modes_test: self-checking bench for uc_top
// assumes uc_remote on the serial pins and a short DIV to keep runs brief
`timescale 1ns/100ps
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("[FAIL] %0t %s: got %h exp %h", $time, m, a, e); end end
module uart_control_and_power_modes_test;
   localparam int DIV = 8;
   logic mclk, rst, bus_wr, bus_rd, stop, dbg, allow, dir0, dir1, ptx, prx;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic rx_hold = 1'b1, en = 1'b0, inv = 1'b0, nine = 1'b0;
   wire logic [7:0] rdata;
   wire logic tx_pin, tx_oe, rx_out, rx_oe, tx_irq, rx_irq, rem_line, rx_wire, tx_wire;
   int mismatches = 0;
   int num_checks = 0;
   // undriven pins rest high through their pull-ups
   assign tx_wire = tx_oe ? tx_pin : 1'b1;
   assign rx_wire = rx_oe ? rx_out : (rem_line & rx_hold);
   uc_top #(.DIV(DIV)) uc_top_i (.mclk_i(mclk), .sys_rst_i(rst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(bus_wr), .rd_i(bus_rd), .rdata_o(rdata), .stop_mode_i(stop),
      .dbg_break_i(dbg), .break_clear_allow_i(allow), .pin0_direction_i(dir0),
      .pin1_direction_i(dir1), .port_tx_data_i(ptx), .port_rx_data_i(prx),
      .tx_pin_o(tx_pin), .tx_pin_oe_o(tx_oe), .rx_pin_i(rx_wire), .rx_pin_o(rx_out),
      .rx_pin_oe_o(rx_oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
   uc_remote #(.DIV(DIV)) uc_remote_i (.clk_i(mclk), .en_i(en), .inv_i(inv), .nine_i(nine),
      .line_i(tx_wire), .line_o(rem_line));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus_wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge mclk);
      bus_rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_rx_irq;
      for (int k = 0; k < 200 && rx_irq !== 1'b1; k++) @(posedge mclk);
   endtask
   function automatic logic [8:0] exp_frame(input logic [7:0] lc, input logic [7:0] b);
      logic [8:0] f;
      f = {1'b0, b};
      if (lc[1] && lc[4]) f[8] = ^b ^ lc[0];
      if (lc[1] && !lc[4]) f[7] = ^b[6:0] ^ lc[0];
      return f;
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset_pins;
      logic [7:0] v;
      reg_rd(2'h0, v); `CHK(v, 8'h00, "line reset")
      reg_rd(2'h1, v); `CHK(v, 8'h00, "xfer reset")
      reg_rd(2'h2, v); `CHK(v, 8'hc0, "status reset")
      `CHK(tx_oe, 1'b0, "tx pin follows port")
      `CHK(rx_oe, 1'b1, "rx pin follows port")
      `CHK(tx_pin, 1'b0, "tx pin port level")
      `CHK(rx_out, 1'b1, "rx pin port level")
      reg_wr(2'h0, 8'h40);
      repeat (2) @(posedge mclk);
      `CHK(tx_oe, 1'b1, "tx pin driven")
      `CHK(rx_oe, 1'b0, "rx pin input")
      reg_wr(2'h1, 8'hc0);
      repeat (3) @(posedge mclk);
      `CHK(tx_irq, 1'b1, "tx request")
      stop <= 1'b1;
      reg_wr(2'h1, 8'h40);
      reg_rd(2'h1, v); `CHK(v, 8'h40, "kept in stop")
      stop <= 1'b0;
      reg_wr(2'h0, 8'h00);
      repeat (3) @(posedge mclk);
      `CHK(tx_irq, 1'b0, "tx request off")
      reg_rd(2'h2, v); `CHK(v[7:6], 2'b11, "empty and done")
      // enable the module again before touching the enables
      reg_wr(2'h0, 8'h40);
      reg_wr(2'h1, 8'h00);
   endtask
   task automatic t_tx(input logic [7:0] lc, input logic [7:0] b);
      logic [7:0] s;
      time t0;
      int c, n;
      n = lc[4] ? 11 : 10;
      en <= 1'b0;
      reg_wr(2'h1, 8'h00);
      reg_wr(2'h0, lc);
      repeat (3) @(posedge mclk);
      `CHK(tx_pin, ~lc[5], "idle level")
      inv <= lc[5];
      nine <= lc[4];
      en <= 1'b1;
      c = uc_remote_i.got_cnt;
      reg_wr(2'h1, 8'h08);
      t0 = $time;
      reg_rd(2'h2, s);
      reg_wr(2'h3, b);
      for (int k = 0; k < 3000 && uc_remote_i.got_cnt == c; k++) @(posedge mclk);
      `CHK(uc_remote_i.got_cnt, c + 1, "frame count")
      `CHK(uc_remote_i.got, exp_frame(lc, b), "frame data")
      `CHK(uc_remote_i.got_stop, 1'b1, "stop bit")
      `CHK(uc_remote_i.start_t - t0 >= n * DIV * 10, 1'b1, "preamble short")
      `CHK(uc_remote_i.start_t - t0 < (n + 1) * DIV * 10, 1'b1, "preamble long")
      repeat (DIV) @(posedge mclk);
   endtask
   task automatic t_rx;
      logic [7:0] v;
      en <= 1'b0;
      inv <= 1'b0;
      reg_wr(2'h1, 8'h00);
      reg_wr(2'h0, 8'h40);
      reg_wr(2'h1, 8'h24);
      uc_remote_i.send(9'h05a, 8);
      wait_rx_irq();
      `CHK(rx_irq, 1'b1, "rx request")
      dbg <= 1'b1;
      reg_rd(2'h2, v);
      reg_rd(2'h3, v); `CHK(v, 8'h5a, "rx byte")
      reg_rd(2'h2, v); `CHK(v[5], 1'b1, "protected flag")
      dbg <= 1'b0;
      reg_rd(2'h2, v);
      dbg <= 1'b1;
      reg_rd(2'h3, v);
      reg_rd(2'h2, v); `CHK(v[5], 1'b1, "held in break")
      dbg <= 1'b0;
      reg_rd(2'h3, v);
      reg_rd(2'h2, v); `CHK(v[5], 1'b0, "second step")
      `CHK(rx_irq, 1'b0, "rx request gone")
      uc_remote_i.send(9'h0c3, 8);
      wait_rx_irq();
      dbg <= 1'b1;
      allow <= 1'b1;
      reg_rd(2'h2, v);
      reg_rd(2'h3, v);
      dbg <= 1'b0;
      allow <= 1'b0;
      reg_rd(2'h2, v); `CHK(v[5], 1'b0, "cleared in break")
      uc_remote_i.send(9'h011, 8);
      wait_rx_irq();
      reg_wr(2'h1, 8'h20);
      reg_rd(2'h2, v); `CHK(v[5], 1'b1, "flag kept")
      reg_rd(2'h3, v); `CHK(v, 8'h11, "last byte")
   endtask
   // address-mark wakeup: a byte with a low top bit stays unseen in standby
   task automatic t_wake;
      logic [7:0] v;
      reg_wr(2'h0, 8'h48);
      reg_wr(2'h1, 8'h26);
      uc_remote_i.send(9'h012, 8);
      repeat (DIV) @(posedge mclk);
      reg_rd(2'h2, v); `CHK(v[5], 1'b0, "standby ignores byte")
      `CHK(rx_irq, 1'b0, "no request in standby")
      uc_remote_i.send(9'h092, 8);
      wait_rx_irq();
      `CHK(rx_irq, 1'b1, "mark wakes receiver")
      reg_rd(2'h1, v); `CHK(v, 8'h24, "standby cleared")
      reg_rd(2'h2, v);
      reg_rd(2'h3, v); `CHK(v, 8'h92, "mark byte")
   endtask
   // pin held low so only the internal path can deliver a clean byte
   task automatic t_loop;
      logic [7:0] v;
      rx_hold <= 1'b0;
      reg_wr(2'h1, 8'h00);
      reg_wr(2'h0, 8'hc0);
      reg_wr(2'h1, 8'h0c);
      reg_rd(2'h2, v);
      reg_wr(2'h3, 8'h3c);
      for (int k = 0; k < 300; k++) begin
         reg_rd(2'h2, v);
         if (v[5] === 1'b1) break;
      end
      `CHK(v[5], 1'b1, "loop full")
      reg_rd(2'h3, v); `CHK(v, 8'h3c, "loop byte")
   endtask
   initial begin
      #1000000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      logic [7:0] lcs [7];
      lcs = '{8'h40, 8'h50, 8'h42, 8'h43, 8'h52, 8'h53, 8'h60};
      addr = 2'h0;
      wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      stop = 1'b0;
      dbg = 1'b0;
      allow = 1'b0;
      dir0 = 1'b0;
      dir1 = 1'b1;
      ptx = 1'b0;
      prx = 1'b1;
      rst = 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_reset_pins();
      for (int i = 0; i < 7; i++) t_tx(lcs[i], 8'h07 ^ {i[3:0], 4'h0});
      t_rx();
      t_wake();
      t_loop();
      report_and_stop();
   end
endmodule
